/* File: ldocc_pkg.sv */
// shared constants for the four-channel ldo control link and its controller
package ldocc_pkg;
    // =====================================================
    // channel count and register layout on the device side
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int VSEL_W = 6;
    localparam int DLY_W = 3;
    // even index = channel control, odd index = voltage code
    localparam logic [ADDR_W-1:0] REG_CTRL_A = 3'h0;
    localparam logic [ADDR_W-1:0] REG_VSEL_A = 3'h1;
    // control register fields
    localparam int F_EN = 0;
    localparam int F_DLY_LO = 1;
    localparam int F_DIS = 4;
    localparam int F_LOW_QUIESCENT_BIT = 5;
    localparam int F_UNMASK = 6;
    localparam int F_PG = 7;
    localparam logic [6:0] CTRL_RST = 7'h00;
    // default voltage codes per channel (arbitrary start points)
    localparam logic [VSEL_W-1:0] VSEL_RST [NUM_CH] = '{6'h39, 6'h39, 6'h2c, 6'h2c};
    // =====================================================
    // timing: 25 MHz clock, delay steps in milliseconds
    localparam int CLK_HZ = 25000000;
    localparam int DLY_UNIT_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * DLY_UNIT_MS;
    localparam int CNT_W = 22;
    // =====================================================
    // controller register map (byte addresses)
    localparam logic [3:0] H_CMD = 4'h0;
    localparam logic [3:0] H_STAT = 4'h4;
    localparam logic [3:0] H_ISTAT = 4'h8;
    localparam logic [3:0] H_IMASK = 4'hc;
    localparam int CMD_ADDR_LO = 8;
    localparam int CMD_RD = 16;
    localparam int ST_DATA_LO = 8;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT = 1;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : ldocc_pkg

/* File: ldocc_link_if.sv */
// register link between the ldo device end and its controller end
`timescale 1ns/1ps
interface ldocc_link_if;
    logic reg_wr;
    logic reg_rd;
    logic [ldocc_pkg::ADDR_W-1:0] reg_addr;
    logic [ldocc_pkg::DATA_W-1:0] reg_wdata;
    logic [ldocc_pkg::DATA_W-1:0] reg_rdata;
    logic reg_ack;
    logic irq_n;
    modport device (input reg_wr, input reg_rd, input reg_addr, input reg_wdata,
        output reg_rdata, output reg_ack, output irq_n);
    modport host (output reg_wr, output reg_rd, output reg_addr, output reg_wdata,
        input reg_rdata, input reg_ack, input irq_n);
endinterface : ldocc_link_if

/* File: ldocc_device.sv */
// ldo channel control logic: enables, turn-on delay, fault interrupt
//
// Operation
// - channel follows edges of its enable bit
// - software writes enable 0 then 1
// - software writes enable 1 then 0
// - delay code picks 0 or 2..128 ms
// - discharge engaged only when enabled and off
// - low quiescent bit selects reduced current mode
// - power good flag reads comparator state
// - unmasked undervoltage pulls irq_n low
// - irq_n releases after recovery and flag read
// - voltage codes start at default, then writable
// - six bit voltage code per channel
`timescale 1ns/1ps
module ldocc_device #(
    // cycles per delay millisecond, shortened in simulation
    parameter int MS_CYCLES = ldocc_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register link
    ldocc_link_if.device link,
    // analog comparator inputs, high while output is in regulation
    input wire logic [ldocc_pkg::NUM_CH-1:0] pg_in,
    // regulator controls
    output logic [ldocc_pkg::NUM_CH-1:0] ldo_on,
    output logic [ldocc_pkg::NUM_CH-1:0] discharge_on,
    output logic [ldocc_pkg::NUM_CH-1:0] low_iq_on,
    output logic [ldocc_pkg::NUM_CH*ldocc_pkg::VSEL_W-1:0] vsel_out
);
    // =====================================================
    // shared decode
    localparam int CH_W = 2;
    logic [CH_W-1:0] sel_ch; // channel addressed by the link
    logic sel_vsel; // odd index selects the voltage code
    logic [ldocc_pkg::NUM_CH-1:0] fault_reg; // per channel latched fault
    logic [ldocc_pkg::NUM_CH-1:0] pg_s2; // synchronised power good
    logic [6:0] ctrl_reg [ldocc_pkg::NUM_CH]; // writable control bits
    logic [ldocc_pkg::VSEL_W-1:0] vsel_reg [ldocc_pkg::NUM_CH]; // voltage codes

    localparam int ADDR_HI = ldocc_pkg::ADDR_W - 1;
    assign sel_ch = link.reg_addr[ADDR_HI:1];
    assign sel_vsel = link.reg_addr[0];

    // =====================================================
    // per channel logic
    genvar c;
    generate
        for (c = 0; c < ldocc_pkg::NUM_CH; c++) begin : g_ch
            logic pg_s1; // first sync stage, read only by pg_s2
            logic wr_ctrl; // control write to this channel
            logic wr_vsel; // voltage write to this channel
            logic rd_ctrl; // control read of this channel
            logic new_en; // enable value being written
            logic pend_reg; // turn-on delay running
            logic seen_reg; // flag read since the fault latched
            logic [ldocc_pkg::CNT_W-1:0] cnt_reg; // delay countdown
            logic [ldocc_pkg::CNT_W-1:0] dly_cycles; // length of chosen delay
            logic [ldocc_pkg::DLY_W-1:0] code; // delay code being written
            logic fault_set; // unmasked undervoltage this cycle
            logic rise_now; // zero delay turn-on this cycle

            assign wr_ctrl = link.reg_wr && (sel_ch == c) && !sel_vsel;
            assign wr_vsel = link.reg_wr && (sel_ch == c) && sel_vsel;
            assign rd_ctrl = link.reg_rd && (sel_ch == c) && !sel_vsel;
            assign new_en = link.reg_wdata[ldocc_pkg::F_EN];
            assign code = link.reg_wdata[ldocc_pkg::F_DLY_LO +: ldocc_pkg::DLY_W];
            // zero delay turn-on, so discharge drops in the same edge
            assign rise_now = wr_ctrl && new_en && code == '0
                && !ctrl_reg[c][ldocc_pkg::F_EN];
            // doubling delay table
            // code n above 0 gives 2^n ms, so the count is a shift of the unit
            assign dly_cycles = ldocc_pkg::CNT_W'(MS_CYCLES << code);
            assign fault_set = ctrl_reg[c][ldocc_pkg::F_UNMASK] && !pg_s2[c];

            // comparator is asynchronous to aclk
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pg_s1 <= 1'b0;
                    pg_s2[c] <= 1'b0;
                end else begin
                    pg_s1 <= pg_in[c];
                    pg_s2[c] <= pg_s1;
                end
            end

            // control and voltage registers
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ctrl_reg[c] <= ldocc_pkg::CTRL_RST;
                    vsel_reg[c] <= ldocc_pkg::VSEL_RST[c];
                end else begin
                    if (wr_ctrl) begin
                        ctrl_reg[c] <= link.reg_wdata[6:0];
                    end
                    if (wr_vsel) begin
                        vsel_reg[c] <= link.reg_wdata[ldocc_pkg::VSEL_W-1:0];
                    end
                end
            end

            // turn-on sequencing
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ldo_on[c] <= 1'b0;
                    pend_reg <= 1'b0;
                    cnt_reg <= '0;
                end else if (wr_ctrl && new_en != ctrl_reg[c][ldocc_pkg::F_EN]) begin
                    // edge acts, level write does not
                    // same-level writes never reach this branch
                    if (new_en) begin
                        // delay starts at rise
                        // the delay uses the code being written with the edge
                        if (code == '0) begin
                            ldo_on[c] <= 1'b1;
                        end else begin
                            pend_reg <= 1'b1;
                            cnt_reg <= dly_cycles - 1'b1;
                        end
                    end else begin
                        ldo_on[c] <= 1'b0;
                        pend_reg <= 1'b0;
                    end
                end else if (pend_reg) begin
                    if (cnt_reg == '0) begin
                        ldo_on[c] <= 1'b1;
                        pend_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
            end

            // fault latch, released by recovery plus a flag read
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    fault_reg[c] <= 1'b0;
                    seen_reg <= 1'b0;
                end else if (fault_set) begin
                    // set wins over any release this cycle
                    fault_reg[c] <= 1'b1;
                    seen_reg <= rd_ctrl && fault_reg[c] ? 1'b1 : seen_reg && fault_reg[c];
                end else if (fault_reg[c]) begin
                    // off or back in regulation, and read
                    if ((rd_ctrl || seen_reg) && (!ldo_on[c] || pg_s2[c])) begin
                        fault_reg[c] <= 1'b0;
                        seen_reg <= 1'b0;
                    end else if (rd_ctrl) begin
                        seen_reg <= 1'b1;
                    end
                end
            end

            // pin style outputs, all from flops
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    discharge_on[c] <= 1'b0;
                    low_iq_on[c] <= 1'b0;
                    vsel_out[c*ldocc_pkg::VSEL_W +: ldocc_pkg::VSEL_W] <= ldocc_pkg::VSEL_RST[c];
                end else begin
                    discharge_on[c] <= ctrl_reg[c][ldocc_pkg::F_DIS] && !ldo_on[c]
                        && !(pend_reg && cnt_reg == '0) && !rise_now;
                    low_iq_on[c] <= ctrl_reg[c][ldocc_pkg::F_LOW_QUIESCENT_BIT];
                    vsel_out[c*ldocc_pkg::VSEL_W +: ldocc_pkg::VSEL_W] <= vsel_reg[c];
                end
            end
        end
    endgenerate

    // =====================================================
    // link answer: one cycle after each strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.reg_ack <= 1'b0;
            link.reg_rdata <= '0;
        end else begin
            link.reg_ack <= link.reg_wr || link.reg_rd;
            if (link.reg_rd) begin
                if (sel_vsel) begin
                    link.reg_rdata <= {2'h0, vsel_reg[sel_ch]};
                end else begin
                    link.reg_rdata <= {pg_s2[sel_ch], ctrl_reg[sel_ch]};
                end
            end
        end
    end

    // shared active low interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.irq_n <= 1'b1;
        end else begin
            link.irq_n <= ~|fault_reg;
        end
    end
endmodule : ldocc_device

/* File: ldocc_host.sv */
// controller end: axi4-lite registers that drive the ldo register link
`timescale 1ns/1ps
module ldocc_host (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt to the system
    output logic irq,
    // link to the device
    ldocc_link_if.host link
);
    // =====================================================
    // state
    logic aw_held; // address latched, waiting for data
    logic w_held; // data latched, waiting for address
    logic [3:0] awaddr_reg; // latched write address
    logic [31:0] wdata_reg; // latched write data
    logic busy_reg; // link access outstanding
    logic [7:0] rdata_reg; // last byte read from device
    logic [1:0] istat_reg; // sticky events
    logic [1:0] imask_reg; // event enables
    logic irq_n_d; // previous irq_n for edge detect
    logic do_wr; // write commits this cycle
    logic cmd_go; // command accepted
    logic [1:0] ev; // events this cycle

    assign do_wr = aw_held && w_held && !s_axi_bvalid;
    assign cmd_go = do_wr && awaddr_reg == ldocc_pkg::H_CMD && !busy_reg
        && s_axi_wstrb != 4'h0;
    assign ev[ldocc_pkg::IRQ_DONE] = link.reg_ack;
    assign ev[ldocc_pkg::IRQ_FAULT] = irq_n_d && !link.irq_n;

    // =====================================================
    // axi write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ldocc_pkg::RESP_OK;
        end else begin
            // ready pulses for one cycle per accepted beat
            s_axi_awready <= !aw_held && s_axi_awvalid && !s_axi_awready;
            s_axi_wready <= !w_held && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // status is read only; only cmd, istat, imask take writes
                s_axi_bresp <= (awaddr_reg == ldocc_pkg::H_STAT) ? ldocc_pkg::RESP_ERR
                    : ldocc_pkg::RESP_OK;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // command launch: one strobe, then wait for the device ack
    // a command written while busy is dropped, software polls busy first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_reg <= 1'b0;
            rdata_reg <= 8'h00;
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            link.reg_addr <= '0;
            link.reg_wdata <= '0;
        end else begin
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            if (cmd_go) begin
                busy_reg <= 1'b1;
                link.reg_rd <= wdata_reg[ldocc_pkg::CMD_RD];
                link.reg_wr <= !wdata_reg[ldocc_pkg::CMD_RD];
                link.reg_addr <= wdata_reg[ldocc_pkg::CMD_ADDR_LO +: ldocc_pkg::ADDR_W];
                link.reg_wdata <= wdata_reg[7:0];
            end else if (link.reg_ack) begin
                busy_reg <= 1'b0;
                rdata_reg <= link.reg_rdata;
            end
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_reg <= 2'h0;
            imask_reg <= 2'h0;
            irq_n_d <= 1'b1;
            irq <= 1'b0;
        end else begin
            irq_n_d <= link.irq_n;
            if (do_wr && awaddr_reg == ldocc_pkg::H_ISTAT) begin
                istat_reg <= (istat_reg & ~wdata_reg[1:0]) | ev;
            end else begin
                istat_reg <= istat_reg | ev;
            end
            if (do_wr && awaddr_reg == ldocc_pkg::H_IMASK) begin
                imask_reg <= wdata_reg[1:0];
            end
            irq <= |(istat_reg & imask_reg);
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= ldocc_pkg::RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= ldocc_pkg::RESP_OK;
                case (s_axi_araddr)
                    ldocc_pkg::H_CMD: s_axi_rdata <= 32'h0;
                    ldocc_pkg::H_STAT: s_axi_rdata <= {16'h0, rdata_reg, 7'h0, busy_reg};
                    ldocc_pkg::H_ISTAT: s_axi_rdata <= {30'h0, istat_reg};
                    ldocc_pkg::H_IMASK: s_axi_rdata <= {30'h0, imask_reg};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= ldocc_pkg::RESP_ERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : ldocc_host

/* File: ldocc_checker.sv */
// concurrent checks on the ldo register link and channel outputs
`timescale 1ns/1ps
module ldocc_checker #(
    parameter int MS_CYCLES = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link signals
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ldocc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ldocc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic irq_n,
    // channel pins
    input wire logic [ldocc_pkg::NUM_CH-1:0] pg_in,
    input wire logic [ldocc_pkg::NUM_CH-1:0] ldo_on,
    input wire logic [ldocc_pkg::NUM_CH-1:0] discharge_on
);
    // =====================================================
    // helper state
    localparam int D1M = 2 * MS_CYCLES - 1; // last quiet cycle of code 1
    logic [3:0] en_q; // shadow of the enable bits
    logic [3:0] unm_q; // shadow of the unmask bits
    logic rd_seen; // control read seen while irq_n low
    logic ctl_wr; // write to a control byte
    logic rise; // write that raises an enable bit
    logic [1:0] ch; // channel addressed
    assign ch = reg_addr[2:1];
    assign ctl_wr = reg_wr && !reg_addr[0];
    assign rise = ctl_wr && reg_wdata[ldocc_pkg::F_EN] && !en_q[ch];
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // shadows track writes, so edges are judged as the device sees them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= 4'h0;
            unm_q <= 4'h0;
        end else if (ctl_wr) begin
            en_q[ch] <= reg_wdata[ldocc_pkg::F_EN];
            unm_q[ch] <= reg_wdata[ldocc_pkg::F_UNMASK];
        end
    end
    // reads before the fault do not count, so clear while irq_n high
    always_ff @(posedge aclk) begin
        if (!aresetn || irq_n) begin
            rd_seen <= 1'b0;
        end else if (reg_rd && !reg_addr[0]) begin
            rd_seen <= 1'b1;
        end
    end
    // =====================================================
    // link handshake
    ack_after_strobe_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("link strobe not acknowledged next cycle");
    ack_pulse_a: assert property (reg_ack |=> !reg_ack)
        else $error("link ack longer than one cycle");
    ack_cause_a: assert property (reg_ack |-> $past(reg_wr || reg_rd))
        else $error("link ack without a strobe");
    // =====================================================
    // channel control
    discharge_off_a: assert property ((discharge_on & ldo_on) == 4'h0)
        else $error("discharge engaged on a live channel");
    enable_fall_a: assert property (
        ctl_wr && !reg_wdata[0] && en_q[ch] |=> !ldo_on[$past(ch)])
        else $error("falling enable did not switch off");
    zero_delay_a: assert property (
        rise && reg_wdata[3:1] == 3'h0 |=> ldo_on[$past(ch)])
        else $error("zero delay channel not on");
    delay_one_a: assert property (
        rise && ch == 2'h0 && reg_wdata[3:1] == 3'h1
        |=> !ldo_on[0] ##D1M !ldo_on[0] ##1 ldo_on[0])
        else $error("code one delay wrong");
    irq_release_a: assert property ($rose(irq_n) |-> rd_seen)
        else $error("irq released without a control read");
    irq_cause_a: assert property (
        $fell(irq_n) |-> (unm_q & ~$past(pg_in, 3)) != 4'h0)
        else $error("irq without unmasked undervoltage");
endmodule : ldocc_checker

/* File: tb_top.sv */
// self-checking bench: axi host and ldo device joined over their link
`timescale 1ns/1ps
module tb_top;
    // =====================================================
    // signals
    localparam int MS = 4; // shortened millisecond
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [3:0] pg_in = 4'hf; // all channels in regulation
    logic [3:0] ldo_on, discharge_on, low_iq_on, on_prev;
    logic [23:0] vsel_out;
    int miscompares = 0, checks_done = 0, cyc = 0, ack_cyc = 0;
    int rise_cyc [4];
    ldocc_link_if link();
    ldocc_host i_ldocc_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .link(link));
    ldocc_device #(.MS_CYCLES(MS)) i_ldocc_device (.aclk(aclk), .aresetn(aresetn),
        .link(link), .pg_in(pg_in), .ldo_on(ldo_on), .discharge_on(discharge_on),
        .low_iq_on(low_iq_on), .vsel_out(vsel_out));
    ldocc_checker #(.MS_CYCLES(MS)) i_ldocc_checker (.aclk(aclk), .aresetn(aresetn),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack), .irq_n(link.irq_n),
        .pg_in(pg_in), .ldo_on(ldo_on), .discharge_on(discharge_on));
    // =====================================================
    // clock and cycle stamps of link acks and turn-ons
    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        on_prev <= ldo_on;
        if (link.reg_ack === 1'b1) ack_cyc <= cyc;
        for (int i = 0; i < 4; i++) if (ldo_on[i] && !on_prev[i]) rise_cyc[i] <= cyc;
    end
    // =====================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // both channels offered together, each released when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awd, wd;
        awd = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(awd && wd)) begin
            @(posedge aclk);
            if (!awd && awready) begin
                awd = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    // one link transfer, polled until the host reports idle
    task automatic lk(input logic rd, input logic [2:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [31:0] s;
        logic [1:0] r;
        axi_wr(ldocc_pkg::H_CMD, {15'h0, rd, 5'h0, a, d}, r);
        do axi_rd(ldocc_pkg::H_STAT, s, r); while (s[0] !== 1'b0);
        q = s[15:8];
    endtask : lk
    // =====================================================
    // watchdog, well beyond the expected run length
    initial begin
        repeat (60000) @(posedge aclk);
        miscompares++;
        end_sim();
    end
    // =====================================================
    // main sequence
    initial begin
        logic [7:0] q, cb;
        logic [5:0] v;
        logic [31:0] s;
        logic [1:0] r;
        logic lq;
        int ch, t0;
        void'($urandom(75));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        // defaults, then random voltage codes per channel
        for (int c = 0; c < 4; c++) begin
            lk(1'b1, 3'(2 * c), 8'h00, q);
            chk(q, 8'h80);
            lk(1'b1, 3'(2 * c + 1), 8'h00, q);
            chk(q, {2'b00, ldocc_pkg::VSEL_RST[c]});
            chk(vsel_out[6 * c +: 6], ldocc_pkg::VSEL_RST[c]);
            v = 6'($urandom);
            lk(1'b0, 3'(2 * c + 1), {2'b11, v}, q);
            lk(1'b1, 3'(2 * c + 1), 8'h00, q);
            chk(q, {2'b00, v});
            chk(vsel_out[6 * c +: 6], v);
        end
        // every delay code, discharge armed, random low quiescent bit
        for (int k = 0; k < 8; k++) begin
            ch = (k + 3) % 4;
            lq = 1'($urandom);
            cb = {2'b00, lq, 1'b1, 3'(k), 1'b0};
            lk(1'b0, 3'(2 * ch), cb, q);
            lk(1'b0, 3'(2 * ch), cb | 8'h01, q);
            t0 = ack_cyc;
            repeat (MS * (1 << k) + 20) @(posedge aclk);
            chk(rise_cyc[ch] - t0, (k == 0) ? 0 : MS * (1 << k));
            chk(low_iq_on[ch], lq);
            chk(discharge_on[ch], 1'b0);
            lk(1'b0, 3'(2 * ch), cb | 8'h01, q);
            chk(ldo_on[ch], 1'b1);
            lk(1'b0, 3'(2 * ch), cb, q);
            chk(ldo_on[ch], 1'b0);
            chk(discharge_on[ch], 1'b1);
        end
        lk(1'b0, 3'h0, 8'h00, q);
        repeat (2) @(posedge aclk);
        chk(discharge_on[0], 1'b0);
        // longest delay cancelled by a falling edge while counting
        lk(1'b0, 3'h2, 8'h0e, q);
        lk(1'b0, 3'h2, 8'h0f, q);
        repeat (20) @(posedge aclk);
        lk(1'b0, 3'h2, 8'h0e, q);
        repeat (600) @(posedge aclk);
        chk(ldo_on[1], 1'b0);
        // fault on channel 2: read early, then read only after recovery
        axi_wr(ldocc_pkg::H_IMASK, 32'h2, r);
        lk(1'b0, 3'h4, 8'h41, q);
        for (int p = 0; p < 2; p++) begin
            pg_in[2] <= 1'b0;
            repeat (10) @(posedge aclk);
            chk(link.irq_n, 1'b0);
            if (p == 0) lk(1'b1, 3'h4, 8'h00, q);
            if (p == 0) chk(q, 8'h41);
            pg_in[2] <= 1'b1;
            repeat (10) @(posedge aclk);
            chk(link.irq_n, p == 0);
            lk(1'b1, 3'h4, 8'h00, q);
            chk(q, 8'hc1);
            repeat (4) @(posedge aclk);
            chk(link.irq_n, 1'b1);
        end
        // host interrupt: masked, unmasked, cleared by writing ones
        chk(irq, 1'b1);
        axi_wr(ldocc_pkg::H_IMASK, 32'h0, r);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        axi_wr(ldocc_pkg::H_IMASK, 32'h2, r);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        axi_wr(ldocc_pkg::H_ISTAT, 32'h3, r);
        axi_rd(ldocc_pkg::H_ISTAT, s, r);
        chk(s, 32'h0);
        chk(r, ldocc_pkg::RESP_OK);
        chk(irq, 1'b0);
        // status is read only on the host side
        axi_wr(ldocc_pkg::H_STAT, 32'h0, r);
        chk(r, ldocc_pkg::RESP_ERR);
        end_sim();
    end
endmodule : tb_top
